// ==== hw/cicr_ctl_regs.v ====
`timescale 1ns/100ps
`include "cicr_consts.vh"

// How it works
// - IRQ-routed Non-secure level-1 binary point goes virtual
// - Banked copies; Secure/Non-secure level gating, never level 0
// - Non-secure level 1 reaches physical only unrouted
// - Sysreg enable clear traps level-1 access
// - Hypervisor common trap sends Non-secure level 1
// - Both monitor routes set trap to level 3
// - 32-bit register, listed reserved bit ranges
// - Bit 15 affinity-3 valid, read-only
// - Bit 14 error-interrupt support, mirrors level 3
// - Bits 13:11 identifier width, read-only
// - Bits 10:8 priority bits minus one
// - Two security states give five priority bits
// - Single security state gives four priority bits
// - Priority count same everywhere, level-3 field
// - Bit 6 enables priority-mask distribution hint
// - Hint mirrors level 3, writable when security-disabled
// - Without level 3, hint writable, resets zero
// - Bit 1 end-of-interrupt mode, per copy mirrored
// - Bit 0 selects common binary point usage
// - Common binary point mirrors level 3, gated writes
// - Level-3 register only at level 3, trappable
module cicr_ctl_regs #(
  parameter HAS_EL3 = 1,
  parameter A3V_VAL = 0,
  parameter SYS_ERROR_INT_SUPPORT_VAL = 0,
  parameter NDS_VAL = 0
) (
  input wire core_clk,
  input wire rst_b,
  input wire sr_req,
  input wire sr_write,
  input wire [15:0] sr_enc,
  input wire [1:0] sr_el,
  input wire sr_ns,
  input wire [31:0] sr_wdata,
  input wire sysreg_enable_el1,
  input wire sysreg_enable_el3,
  input wire hyp_fiq_route,
  input wire hyp_irq_route,
  input wire hyp_common_trap,
  input wire monitor_fiq_route,
  input wire monitor_irq_route,
  input wire security_disable,
  output reg sr_done_ff,
  output reg [31:0] sr_rdata_ff,
  output reg sr_undef_ff,
  output reg sr_trap_el1_ff,
  output reg sr_trap_el2_ff,
  output reg sr_trap_el3_ff,
  output reg sr_virtual_ff,
  output reg sr_unclaimed_ff,
  output reg priority_mask_hint_enable_ff,
  output reg end_of_int_mode_s_ff,
  output reg end_of_int_mode_ns_ff,
  output reg end_of_int_mode_el3_ff,
  output reg common_binary_point_s_ff,
  output reg common_binary_point_ns_ff,
  output reg routing_modifier_ff
);

  wire g_undef;
  wire g_trap1;
  wire g_trap2;
  wire g_trap3;
  wire g_virt;
  wire g_unclaimed;
  wire hit_s;
  wire hit_ns;
  wire hit3;
  wire [2:0] priority_width;
  wire [2:0] identifier_width;
  wire affinity3_valid;
  wire sys_error_int_support;
  wire el1_gated_wr;
  wire wr_s;
  wire wr_ns;
  wire wr3;
  wire hit_el1;
  wire cur_eoi;
  wire cur_common_binary_point;
  reg [31:0] nxt_rdata;
  reg [31:0] ctl1_view;
  reg [31:0] ctl3_view;
  reg nxt_priority_mask_hint_enable;
  reg nxt_eoi_s;
  reg nxt_eoi_ns;
  reg nxt_eoi_el3;
  reg nxt_common_binary_point_s;
  reg nxt_common_binary_point_ns;
  reg nxt_rm;

  cicr_access_gate #(
    .HAS_EL3(HAS_EL3)
  ) u_gate (
    .el(sr_el),
    .ns(sr_ns),
    .enc(sr_enc),
    .sysreg_enable_el1(sysreg_enable_el1),
    .sysreg_enable_el3(sysreg_enable_el3),
    .hyp_fiq_route(hyp_fiq_route),
    .hyp_irq_route(hyp_irq_route),
    .hyp_common_trap(hyp_common_trap),
    .monitor_fiq_route(monitor_fiq_route),
    .monitor_irq_route(monitor_irq_route),
    .undef(g_undef),
    .trap_el1(g_trap1),
    .trap_el2(g_trap2),
    .trap_el3(g_trap3),
    .to_virtual(g_virt),
    .unclaimed(g_unclaimed),
    .hit_ctl1_s(hit_s),
    .hit_ctl1_ns(hit_ns),
    .hit_ctl3(hit3)
  );

  // Feature fields are straps of this build, same for every view
  assign priority_width = (HAS_EL3 != 0) ? `CICR_PRI_M1_TWO_SEC : `CICR_PRI_M1_ONE_SEC;
  assign identifier_width = `CICR_ID_16BIT;
  assign affinity3_valid = (A3V_VAL != 0);
  assign sys_error_int_support = (SYS_ERROR_INT_SUPPORT_VAL != 0);

  assign hit_el1 = hit_s | hit_ns;
  assign wr_s = sr_req && sr_write && hit_s;
  assign wr_ns = sr_req && sr_write && hit_ns;
  assign wr3 = sr_req && sr_write && hit3;
  // Level-1 view may only touch hint and common point when security is off
  assign el1_gated_wr = (HAS_EL3 == 0) || security_disable;

  assign cur_eoi = hit_s ? end_of_int_mode_s_ff : end_of_int_mode_ns_ff;
  assign cur_common_binary_point = hit_s ? common_binary_point_s_ff : common_binary_point_ns_ff;

  // Level-1 view: feature straps plus the bits of the accessing copy
  always @*
  begin
    ctl1_view = 32'h0000_0000;
    ctl1_view[`CICR_A3V_BIT] = affinity3_valid;
    ctl1_view[`CICR_SYS_ERROR_INT_SUPPORT_BIT] = sys_error_int_support;
    ctl1_view[`CICR_ID_MSB:`CICR_ID_LSB] = identifier_width;
    ctl1_view[`CICR_PRI_MSB:`CICR_PRI_LSB] = priority_width;
    ctl1_view[`CICR_PRIORITY_MASK_HINT_ENABLE_BIT] = priority_mask_hint_enable_ff;
    ctl1_view[`CICR_C1_EOI_BIT] = cur_eoi;
    ctl1_view[`CICR_C1_COMMON_BINARY_POINT_BIT] = cur_common_binary_point;
  end

  // Level-3 view: every banked bit side by side
  always @*
  begin
    ctl3_view = 32'h0000_0000;
    ctl3_view[`CICR_C3_NDS_BIT] = (NDS_VAL != 0);
    ctl3_view[`CICR_A3V_BIT] = affinity3_valid;
    ctl3_view[`CICR_SYS_ERROR_INT_SUPPORT_BIT] = sys_error_int_support;
    ctl3_view[`CICR_ID_MSB:`CICR_ID_LSB] = identifier_width;
    ctl3_view[`CICR_PRI_MSB:`CICR_PRI_LSB] = priority_width;
    ctl3_view[`CICR_PRIORITY_MASK_HINT_ENABLE_BIT] = priority_mask_hint_enable_ff;
    ctl3_view[`CICR_C3_RM_BIT] = routing_modifier_ff;
    ctl3_view[`CICR_C3_EOI_NS_BIT] = end_of_int_mode_ns_ff;
    ctl3_view[`CICR_C3_EOI_S_BIT] = end_of_int_mode_s_ff;
    ctl3_view[`CICR_C3_EOI_EL3_BIT] = end_of_int_mode_el3_ff;
    ctl3_view[`CICR_C3_COMMON_BINARY_POINT_NS_BIT] = common_binary_point_ns_ff;
    ctl3_view[`CICR_C3_COMMON_BINARY_POINT_S_BIT] = common_binary_point_s_ff;
  end

  // Misses and refusals read as zero
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    if (hit_el1)
      nxt_rdata = ctl1_view;
    else if (hit3)
      nxt_rdata = ctl3_view;
  end

  // One storage bit per field; both views alias it, except the level-3-only EOI and routing modifier bits
  always @*
  begin
    nxt_priority_mask_hint_enable = priority_mask_hint_enable_ff;
    nxt_eoi_s = end_of_int_mode_s_ff;
    nxt_eoi_ns = end_of_int_mode_ns_ff;
    nxt_eoi_el3 = end_of_int_mode_el3_ff;
    nxt_common_binary_point_s = common_binary_point_s_ff;
    nxt_common_binary_point_ns = common_binary_point_ns_ff;
    nxt_rm = routing_modifier_ff;
    if (wr3)
    begin
      nxt_priority_mask_hint_enable = sr_wdata[`CICR_PRIORITY_MASK_HINT_ENABLE_BIT];
      nxt_rm = sr_wdata[`CICR_C3_RM_BIT];
      nxt_eoi_ns = sr_wdata[`CICR_C3_EOI_NS_BIT];
      nxt_eoi_s = sr_wdata[`CICR_C3_EOI_S_BIT];
      nxt_eoi_el3 = sr_wdata[`CICR_C3_EOI_EL3_BIT];
      nxt_common_binary_point_ns = sr_wdata[`CICR_C3_COMMON_BINARY_POINT_NS_BIT];
      nxt_common_binary_point_s = sr_wdata[`CICR_C3_COMMON_BINARY_POINT_S_BIT];
    end
    else if (wr_s || wr_ns)
    begin
      if (el1_gated_wr)
      begin
        nxt_priority_mask_hint_enable = sr_wdata[`CICR_PRIORITY_MASK_HINT_ENABLE_BIT];
        if (wr_s)
          nxt_common_binary_point_s = sr_wdata[`CICR_C1_COMMON_BINARY_POINT_BIT];
        else
          nxt_common_binary_point_ns = sr_wdata[`CICR_C1_COMMON_BINARY_POINT_BIT];
      end
      if (wr_s)
        nxt_eoi_s = sr_wdata[`CICR_C1_EOI_BIT];
      else
        nxt_eoi_ns = sr_wdata[`CICR_C1_EOI_BIT];
    end
  end

  // Response pulses and read data, one cycle after each request
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sr_done_ff <= 1'b0;
      sr_rdata_ff <= 32'h0000_0000;
      sr_undef_ff <= 1'b0;
      sr_trap_el1_ff <= 1'b0;
      sr_trap_el2_ff <= 1'b0;
      sr_trap_el3_ff <= 1'b0;
      sr_virtual_ff <= 1'b0;
      sr_unclaimed_ff <= 1'b0;
    end
    else
    begin
      sr_done_ff <= sr_req;
      // Reads that miss or trap return zero so no state leaks
      sr_rdata_ff <= (sr_req && !sr_write) ? nxt_rdata : 32'h0000_0000;
      sr_undef_ff <= sr_req && g_undef;
      sr_trap_el1_ff <= sr_req && g_trap1;
      sr_trap_el2_ff <= sr_req && g_trap2;
      sr_trap_el3_ff <= sr_req && g_trap3;
      sr_virtual_ff <= sr_req && g_virt;
      sr_unclaimed_ff <= sr_req && g_unclaimed;
    end
  end

  // Hint is one bit seen through every view
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      priority_mask_hint_enable_ff <= `CICR_RST_PRIORITY_MASK_HINT_ENABLE;
    else
      priority_mask_hint_enable_ff <= nxt_priority_mask_hint_enable;
  end

  // Reset value is free; zero keeps runs repeatable
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      end_of_int_mode_s_ff <= `CICR_RST_EOI;
    else
      end_of_int_mode_s_ff <= nxt_eoi_s;
  end

  // Non-secure copy, aliased by its level-3 field
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      end_of_int_mode_ns_ff <= `CICR_RST_EOI;
    else
      end_of_int_mode_ns_ff <= nxt_eoi_ns;
  end

  // Reachable only through the level-3 view
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      end_of_int_mode_el3_ff <= `CICR_RST_EOI;
    else
      end_of_int_mode_el3_ff <= nxt_eoi_el3;
  end

  // Level-1 writes gated by security disable
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      common_binary_point_s_ff <= `CICR_RST_COMMON_BINARY_POINT;
    else
      common_binary_point_s_ff <= nxt_common_binary_point_s;
  end

  // Same gating as the Secure copy
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      common_binary_point_ns_ff <= `CICR_RST_COMMON_BINARY_POINT;
    else
      common_binary_point_ns_ff <= nxt_common_binary_point_ns;
  end

  // Stored only; nothing in this block acts on it
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      routing_modifier_ff <= `CICR_RST_RM;
    else
      routing_modifier_ff <= nxt_rm;
  end

endmodule // cicr_ctl_regs

// ==== hw/cicr_consts.vh ====
`ifndef CICR_CONSTS_VH
`define CICR_CONSTS_VH

// System register encoding {op0, op1, CRn, CRm, op2}
`define CICR_ENC_W 16
`define CICR_ENC_CTL1 16'hc664
`define CICR_ENC_BPR1 16'hc663
`define CICR_ENC_CTL3 16'hf664

// Exception levels
`define CICR_EL0 2'h0
`define CICR_EL1 2'h1
`define CICR_EL2 2'h2
`define CICR_EL3 2'h3

// Field positions shared by both control registers
`define CICR_A3V_BIT 15
`define CICR_SYS_ERROR_INT_SUPPORT_BIT 14
`define CICR_ID_MSB 13
`define CICR_ID_LSB 11
`define CICR_PRI_MSB 10
`define CICR_PRI_LSB 8
`define CICR_PRIORITY_MASK_HINT_ENABLE_BIT 6

// Level-1 control register fields
`define CICR_C1_EOI_BIT 1
`define CICR_C1_COMMON_BINARY_POINT_BIT 0

// Level-3 control register fields
`define CICR_C3_NDS_BIT 17
`define CICR_C3_RM_BIT 5
`define CICR_C3_EOI_NS_BIT 4
`define CICR_C3_EOI_S_BIT 3
`define CICR_C3_EOI_EL3_BIT 2
`define CICR_C3_COMMON_BINARY_POINT_NS_BIT 1
`define CICR_C3_COMMON_BINARY_POINT_S_BIT 0

// Read-only feature values
`define CICR_ID_16BIT 3'h0
`define CICR_ID_24BIT 3'h1
`define CICR_PRI_M1_TWO_SEC 3'h4
`define CICR_PRI_M1_ONE_SEC 3'h3

// Reset values
`define CICR_RST_PRIORITY_MASK_HINT_ENABLE 1'h0
`define CICR_RST_COMMON_BINARY_POINT 1'h0
`define CICR_RST_EOI 1'h0
`define CICR_RST_RM 1'h0

`endif

// ==== hw/cicr_access_gate.v ====
`timescale 1ns/100ps
`include "cicr_consts.vh"

module cicr_access_gate #(
  parameter HAS_EL3 = 1
) (
  input wire [1:0] el,
  input wire ns,
  input wire [15:0] enc,
  input wire sysreg_enable_el1,
  input wire sysreg_enable_el3,
  input wire hyp_fiq_route,
  input wire hyp_irq_route,
  input wire hyp_common_trap,
  input wire monitor_fiq_route,
  input wire monitor_irq_route,
  output reg undef,
  output reg trap_el1,
  output reg trap_el2,
  output reg trap_el3,
  output reg to_virtual,
  output reg unclaimed,
  output reg hit_ctl1_s,
  output reg hit_ctl1_ns,
  output reg hit_ctl3
);

  wire is_ctl1;
  wire is_bpr1;
  wire is_ctl3;
  wire at_el1_ns;
  wire hyp_routed;
  wire mon_both;

  assign is_ctl1 = (enc == `CICR_ENC_CTL1);
  assign is_bpr1 = (enc == `CICR_ENC_BPR1);
  assign is_ctl3 = (enc == `CICR_ENC_CTL3);
  assign at_el1_ns = (el == `CICR_EL1) && ns;
  assign hyp_routed = hyp_fiq_route | hyp_irq_route;
  assign mon_both = (HAS_EL3 != 0) && monitor_fiq_route && monitor_irq_route;

  always @*
  begin
    undef = 1'b0;
    trap_el1 = 1'b0;
    trap_el2 = 1'b0;
    trap_el3 = 1'b0;
    to_virtual = 1'b0;
    unclaimed = 1'b0;
    hit_ctl1_s = 1'b0;
    hit_ctl1_ns = 1'b0;
    hit_ctl3 = 1'b0;
    if (is_bpr1)
    begin
      if (at_el1_ns && hyp_irq_route)
        to_virtual = 1'b1;
      else
        unclaimed = 1'b1;
    end
    else if (is_ctl1)
    begin
      if (el == `CICR_EL0)
        undef = 1'b1;
      else if ((el == `CICR_EL1) && !sysreg_enable_el1)
        trap_el1 = 1'b1;
      else if (at_el1_ns && hyp_common_trap)
        trap_el2 = 1'b1;
      else if (at_el1_ns && hyp_routed)
        to_virtual = 1'b1;
      else if (mon_both && (el == `CICR_EL1 || el == `CICR_EL2))
        trap_el3 = 1'b1;
      else if ((el == `CICR_EL3) && (HAS_EL3 == 0))
        undef = 1'b1;
      else if (!ns && (el == `CICR_EL1 || el == `CICR_EL3))
        hit_ctl1_s = 1'b1;
      else
        hit_ctl1_ns = 1'b1;
    end
    else if (is_ctl3)
    begin
      if ((el != `CICR_EL3) || (HAS_EL3 == 0))
        undef = 1'b1;
      else if (!sysreg_enable_el3)
        trap_el3 = 1'b1;
      else
        hit_ctl3 = 1'b1;
    end
    else
      unclaimed = 1'b1;
  end

endmodule // cicr_access_gate

// ==== tb/cicr_ctl_regs_checker.sv ====
`timescale 1ns/100ps
`include "cicr_consts.vh"

module cicr_ctl_regs_checker #(
  parameter HAS_EL3 = 1
) (
  input wire core_clk,
  input wire rst_b,
  input wire sr_req,
  input wire sr_write,
  input wire [15:0] sr_enc,
  input wire [1:0] sr_el,
  input wire sr_ns,
  input wire sysreg_enable_el1,
  input wire hyp_common_trap,
  input wire hyp_irq_route,
  input wire monitor_fiq_route,
  input wire monitor_irq_route,
  input wire security_disable,
  input wire sr_done_ff,
  input wire [31:0] sr_rdata_ff,
  input wire sr_undef_ff,
  input wire sr_trap_el1_ff,
  input wire sr_trap_el2_ff,
  input wire sr_trap_el3_ff,
  input wire sr_virtual_ff,
  input wire priority_mask_hint_enable_ff
);
  localparam [2:0] PRI_M1 = HAS_EL3 ? `CICR_PRI_M1_TWO_SEC : `CICR_PRI_M1_ONE_SEC;
  wire c1 = sr_req && sr_enc == `CICR_ENC_CTL1;
  wire refused = sr_undef_ff || sr_trap_el1_ff || sr_trap_el2_ff || sr_trap_el3_ff || sr_virtual_ff;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  chk_done_pulse: assert property (sr_req |=> sr_done_ff) else $error("no done after request");
  chk_done_idle: assert property (!sr_req |=> !sr_done_ff) else $error("done without request");
  chk_el0_undef: assert property (c1 && sr_el == `CICR_EL0 |=> sr_undef_ff)
    else $error("level 0 access not refused");
  chk_sre1_trap: assert property (c1 && sr_el == `CICR_EL1 && !sysreg_enable_el1 |=> sr_trap_el1_ff)
    else $error("missing level 1 trap");
  chk_common_trap: assert property (c1 && sr_el == `CICR_EL1 && sr_ns && sysreg_enable_el1 && hyp_common_trap
    |=> sr_trap_el2_ff) else $error("missing level 2 trap");
  chk_monitor_trap: assert property (c1 && sr_el == `CICR_EL2 && monitor_fiq_route && monitor_irq_route
    |=> sr_trap_el3_ff) else $error("missing level 3 trap");
  chk_bpr1_virtual: assert property (sr_req && sr_enc == `CICR_ENC_BPR1 && sr_el == `CICR_EL1 && sr_ns
    && hyp_irq_route |=> sr_virtual_ff) else $error("binary point not redirected");
  chk_ctl3_gate: assert property (sr_req && sr_enc == `CICR_ENC_CTL3 && sr_el != `CICR_EL3 |=> sr_undef_ff)
    else $error("level 3 register reached below level 3");
  chk_pri_field: assert property (HAS_EL3 != 0 && c1 && !sr_write && sr_el == `CICR_EL3
    |=> sr_rdata_ff[31:16] == 16'h0000 && sr_rdata_ff[13:8] == {3'h0, PRI_M1}) else $error("bad feature field");
  chk_hint_locked: assert property (c1 && sr_write && !security_disable
    |=> $stable(priority_mask_hint_enable_ff)) else $error("hint written while locked");
  chk_refused_zero: assert property (refused |-> sr_rdata_ff == 32'h00000000)
    else $error("refused access returned data");
endmodule // cicr_ctl_regs_checker

bind cicr_ctl_regs cicr_ctl_regs_checker #(.HAS_EL3(HAS_EL3)) chk (.*);

// ==== tb/cicr_core_model.sv ====
`timescale 1ns/100ps

module cicr_core_model (
  input wire core_clk,
  input wire sr_done_ff,
  output reg sr_req,
  output reg sr_write,
  output reg [15:0] sr_enc,
  output reg [1:0] sr_el,
  output reg sr_ns,
  output reg [31:0] sr_wdata
);
  initial
  begin
    {sr_req, sr_write, sr_enc, sr_el, sr_ns, sr_wdata} = 53'h0;
  end

  // Caller enters on a rising edge; g idle cycles model a slow core
  task access(input w, input [15:0] e, input [1:0] l, input n, input [31:0] d, input integer g, output ok);
    integer k;
    begin
      repeat (g) @(posedge core_clk);
      {sr_req, sr_write, sr_enc, sr_el, sr_ns, sr_wdata} <= {1'b1, w, e, l, n, d};
      @(posedge core_clk);
      sr_req <= 1'b0;
      // Scramble qualifiers so the design cannot lean on stale values
      sr_enc <= ~e;
      sr_wdata <= ~d;
      sr_write <= ~w;
      #1;
      k = 0;
      while (sr_done_ff !== 1'b1 && k < 4)
      begin
        @(posedge core_clk);
        #1;
        k = k + 1;
      end
      ok = sr_done_ff === 1'b1;
    end
  endtask
endmodule // cicr_core_model

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`include "cicr_consts.vh"

module tb;
  reg core_clk = 1'b0;
  reg rst_b = 1'b0;
  reg sysreg_enable_el1 = 1'b1, sysreg_enable_el3 = 1'b1, hyp_fiq_route = 1'b0, hyp_irq_route = 1'b0;
  reg hyp_common_trap = 1'b0, monitor_fiq_route = 1'b0, monitor_irq_route = 1'b0, security_disable = 1'b0;
  wire sr_req, sr_write, sr_ns, sr_done_ff, sr_undef_ff, sr_trap_el1_ff, sr_trap_el2_ff, sr_trap_el3_ff;
  wire sr_virtual_ff, sr_unclaimed_ff, priority_mask_hint_enable_ff, end_of_int_mode_s_ff, end_of_int_mode_ns_ff;
  wire end_of_int_mode_el3_ff, common_binary_point_s_ff, common_binary_point_ns_ff, routing_modifier_ff;
  wire [15:0] sr_enc;
  wire [1:0] sr_el;
  wire [31:0] sr_wdata, sr_rdata_ff;
  wire [5:0] flags = {sr_undef_ff, sr_trap_el1_ff, sr_trap_el2_ff, sr_trap_el3_ff, sr_virtual_ff, sr_unclaimed_ff};
  wire [6:0] st = {priority_mask_hint_enable_ff, end_of_int_mode_s_ff, end_of_int_mode_ns_ff,
    end_of_int_mode_el3_ff, common_binary_point_s_ff, common_binary_point_ns_ff, routing_modifier_ff};
  reg [6:0] sh = 7'h00;
  reg [15:0] rs = 16'h8341;
  reg [15:0] re;
  integer failures = 0, compares = 0, i, gap = 0;

  cicr_ctl_regs dut (.*);
  cicr_core_model core (.*);

  always #10 core_clk = ~core_clk;

  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function [5:0] exp_flags(input [15:0] e, input [1:0] l, input n);
    begin
      exp_flags = 6'h01;
      if (e == `CICR_ENC_BPR1 && l == `CICR_EL1 && n && hyp_irq_route) exp_flags = 6'h02;
      else if (e == `CICR_ENC_CTL3) exp_flags = l != `CICR_EL3 ? 6'h20 : !sysreg_enable_el3 ? 6'h04 : 6'h00;
      else if (e == `CICR_ENC_CTL1)
      begin
        if (l == `CICR_EL0) exp_flags = 6'h20;
        else if (l == `CICR_EL1 && !sysreg_enable_el1) exp_flags = 6'h10;
        else if (l == `CICR_EL1 && n && hyp_common_trap) exp_flags = 6'h08;
        else if (l == `CICR_EL1 && n && (hyp_fiq_route || hyp_irq_route)) exp_flags = 6'h02;
        else if (l != `CICR_EL3 && monitor_fiq_route && monitor_irq_route) exp_flags = 6'h04;
        else exp_flags = 6'h00;
      end
    end
  endfunction

  function [31:0] exp_data(input [15:0] e, input sec);
    if (e == `CICR_ENC_CTL3)
      exp_data = {18'h0, 6'h04, 1'b0, sh[6], sh[0], sh[4], sh[5], sh[3], sh[1], sh[2]};
    else
      exp_data = {18'h0, 6'h04, 1'b0, sh[6], 4'h0, sec ? sh[5] : sh[4], sec ? sh[2] : sh[1]};
  endfunction

  task cmp_bits(input [6:0] a, input [6:0] x);
    begin
      compares = compares + 1;
      if (a !== x)
      begin
        failures = failures + 1;
        $display("Error at %0t: bits %b expected %b", $time, a, x);
      end
    end
  endtask

  task cmp_data(input [31:0] a, input [31:0] x);
    begin
      compares = compares + 1;
      if (a !== x)
      begin
        failures = failures + 1;
        $display("Error at %0t: data %h expected %h", $time, a, x);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task go(input w, input [15:0] e, input [1:0] l, input n, input [31:0] d);
    reg ok;
    reg sec;
    reg [5:0] xf;
    begin
      core.access(w, e, l, n, d, gap, ok);
      if (!ok)
      begin
        failures = failures + 1;
        $display("Error at %0t: no completion", $time);
        report_and_stop;
      end
      else
      begin
        xf = exp_flags(e, l, n);
        sec = !n && (l == `CICR_EL1 || l == `CICR_EL3);
        cmp_bits({1'b0, flags}, {1'b0, xf});
        cmp_data(sr_rdata_ff, (w || xf != 6'h00) ? 32'h0 : exp_data(e, sec));
        if (w && xf == 6'h00 && e == `CICR_ENC_CTL3) sh = {d[6], d[3], d[4], d[2], d[0], d[1], d[5]};
        else if (w && xf == 6'h00)
        begin
          if (sec) sh[5] = d[1];
          else sh[4] = d[1];
          // Locked mirror bits only move while security is disabled
          if (security_disable) {sh[6], sh[2], sh[1]} = {d[6], sec ? d[0] : sh[2], sec ? sh[1] : d[0]};
        end
        cmp_bits(st, sh);
      end
    end
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    cmp_bits(st, 7'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge core_clk);
      security_disable <= i[0];
      go(1'b1, `CICR_ENC_CTL1, i[1] ? `CICR_EL2 : `CICR_EL1, i[1], 32'hffffffff);
      @(posedge core_clk);
      go(1'b0, `CICR_ENC_CTL1, i[1] ? `CICR_EL2 : `CICR_EL1, i[1], 32'h0);
    end
    for (i = 0; i < 500; i = i + 1)
    begin
      rs = lfsr(rs);
      re = lfsr(rs);
      gap = re[15];
      @(posedge core_clk);
      {sysreg_enable_el1, sysreg_enable_el3, hyp_fiq_route, hyp_irq_route, hyp_common_trap, monitor_fiq_route,
        monitor_irq_route, security_disable} <= {rs[0] | rs[1], rs[2] | rs[3], rs[4] & rs[5], rs[6], rs[8] & rs[9],
        rs[10], rs[11], rs[12]};
      go(re[5], re[1:0] == 2'h3 ? (re[2] ? `CICR_ENC_BPR1 : {re[15:4], 4'h0}) : re[1] ? `CICR_ENC_CTL3
        : `CICR_ENC_CTL1, re[7:6], re[8], {rs, re});
    end
    report_and_stop;
  end
endmodule // tb
